// >>> include/peci_limit_map.svh
// register map constants for the peci limit and version bank
// assumes byte-wide registers on word-aligned avalon addresses
`ifndef PECI_LIMIT_MAP_SVH
`define PECI_LIMIT_MAP_SVH
`define RANGE_ACOU_OFS 8'h3c
`define OT_LIMIT_OFS 8'h3d
`define VERSION_OFS 8'h3f
`define CONFIG1_OFS 8'h40
`define RANGE_ACOU_RST 8'hc0
`define OT_LIMIT_RST 8'h00
`define CONFIG1_RST 8'h04
`define OT_DISABLE_CODE 8'h80
`define SPAN_MSB 7
`define SPAN_LSB 4
`define LOCK_BIT 1
`define REV_MSB 1
`define PECI_CAP_BIT 2
`define FOUR_WIRE_BIT 3
`define FAMILY_MSB 7
`define FAMILY_LSB 4
`define BAD_ADDR_DATA 32'h0000_0000
`endif

// >>> include/peci_limit_pkg.sv
// types for the peci limit and version bank
// assumes the map header is included by users needing numbers
package peci_limit_pkg;
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_ACK = 3'b010,
      BUS_HOLD = 3'b100
   } bus_state_t;
   typedef logic [7:0] reg8_t;
endpackage

// >>> logic/span_decode.sv
// converts the 4-bit span code to a span in quarter-degree steps
// assumes codes follow the documented 16-entry table
`timescale 1ns/10ps
module span_decode (
   input wire logic [3:0] span_code,
   output logic [9:0] span_q2
);
   // span times 4, truncated for the thirds
   always_comb begin
      unique case (span_code)
         4'h0: span_q2 = 10'h008;
         4'h1: span_q2 = 10'h00a;
         4'h2: span_q2 = 10'h00d;
         4'h3: span_q2 = 10'h010;
         4'h4: span_q2 = 10'h014;
         4'h5: span_q2 = 10'h01a;
         4'h6: span_q2 = 10'h020;
         4'h7: span_q2 = 10'h028;
         4'h8: span_q2 = 10'h035;
         4'h9: span_q2 = 10'h040;
         4'ha: span_q2 = 10'h050;
         4'hb: span_q2 = 10'h06a;
         4'hc: span_q2 = 10'h080;
         4'hd: span_q2 = 10'h0a0;
         4'he: span_q2 = 10'h0d5;
         4'hf: span_q2 = 10'h140;
      endcase
   end
endmodule // span_decode

// >>> logic/peci_limit_regs.sv
// peci range, over-temperature limit and version registers
// assumes avalon-mm master on mclk; peci readings given as signed bytes
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`include "peci_limit_map.svh"
module peci_limit_regs
   import peci_limit_pkg::*;
#(
   parameter int NUM_PECI = 4,
   parameter int NUM_PWM = 3,
   parameter logic [1:0] SILICON_REV = 2'h0,
   // arbitrary value
   parameter logic [3:0] FAMILY_VERSION = 4'h1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [1:0] response,
   input wire logic [8*NUM_PECI-1:0] peci_temp,
   input wire logic [NUM_PECI-1:0] peci_valid,
   input wire logic [7:0] hysteresis,
   input wire logic [8*NUM_PWM-1:0] pwm_duty_in,
   output logic [8*NUM_PWM-1:0] pwm_duty_out,
   output logic overtemp_active,
   output logic [3:0] temperature_span,
   output logic [9:0] span_quarter_deg,
   output logic config_locked
);
   bus_state_t state_r, state_nxt;
   reg8_t range_r, limit_r, config1_r;
   logic [31:0] readdata_r;
   logic [1:0] response_r;
   logic ot_r, ot_nxt;

   function automatic logic signed [8:0] sx(input logic [7:0] v);
      sx = {v[7], v};
   endfunction

   // bus decode
   wire logic req = read | write;
   wire logic hit_range = address == `RANGE_ACOU_OFS;
   wire logic hit_limit = address == `OT_LIMIT_OFS;
   wire logic hit_ver = address == `VERSION_OFS;
   wire logic hit_cfg = address == `CONFIG1_OFS;
   wire logic hit_any = hit_range | hit_limit | hit_ver | hit_cfg;
   wire logic take = (state_r == BUS_IDLE) & req;
   wire logic ack = state_r == BUS_ACK;
   // writes land on the edge where waitrequest is seen low
   wire logic wr_lane0 = ack & write & byteenable[0];
   wire logic locked = config1_r[`LOCK_BIT];
   wire logic wr_range = wr_lane0 & hit_range & ~locked;
   wire logic wr_limit = wr_lane0 & hit_limit & ~locked;
   wire logic wr_lock = wr_lane0 & hit_cfg & ~locked;
   // version is hardwired and never written
   wire reg8_t version_val = {FAMILY_VERSION, 1'b1, 1'b1, SILICON_REV};
   wire reg8_t rd_byte = hit_range ? range_r :
      hit_limit ? limit_r :
      hit_ver ? version_val :
      hit_cfg ? config1_r : 8'h00;

   // one wait cycle per access, then ack, then a hold cycle that keeps a back-to-back request waiting
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         BUS_IDLE: begin
            if (req) state_nxt = BUS_ACK;
         end
         BUS_ACK: state_nxt = BUS_HOLD;
         BUS_HOLD: state_nxt = BUS_IDLE;
      endcase
   end
   assign waitrequest = req & ~ack;
   assign readdata = readdata_r;
   assign response = response_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= BUS_IDLE;
         readdata_r <= 32'h0000_0000;
         response_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         if (take) begin
            readdata_r <= hit_any ? {24'h00_0000, rd_byte} : `BAD_ADDR_DATA;
            response_r <= hit_any ? 2'h0 : 2'h3;
         end
      end
   end

   // register storage
   always_ff @(posedge mclk) begin
      if (rst) begin
         range_r <= `RANGE_ACOU_RST;
         limit_r <= `OT_LIMIT_RST;
         config1_r <= `CONFIG1_RST;
      end else begin
         if (wr_range) range_r <= writedata[7:0];
         if (wr_limit) limit_r <= writedata[7:0];
         if (wr_lock) config1_r[`LOCK_BIT] <= writedata[`LOCK_BIT];
      end
   end

   // over-temperature detect with hysteresis
   wire logic ot_enable = limit_r != `OT_DISABLE_CODE;
   wire logic signed [8:0] lim_s = sx(limit_r);
   wire logic signed [8:0] rel_s = lim_s - sx(hysteresis);
   logic any_above, all_below;
   always_comb begin
      any_above = 1'b0;
      all_below = 1'b1;
      for (int i = 0; i < NUM_PECI; i++) begin
         if (peci_valid[i] && sx(peci_temp[8*i +: 8]) > lim_s) any_above = 1'b1;
         if (peci_valid[i] && sx(peci_temp[8*i +: 8]) >= rel_s) all_below = 1'b0;
      end
   end
   always_comb begin
      ot_nxt = ot_r;
      if (!ot_enable) ot_nxt = 1'b0;
      else if (any_above) ot_nxt = 1'b1;
      else if (all_below) ot_nxt = 1'b0;
   end
   always_ff @(posedge mclk) begin
      if (rst) ot_r <= 1'b0;
      else ot_r <= ot_nxt;
   end

   // pwm override
   always_ff @(posedge mclk) begin
      if (rst) pwm_duty_out <= {NUM_PWM{8'hff}};
      else if (ot_r) pwm_duty_out <= {NUM_PWM{8'hff}};
      else pwm_duty_out <= pwm_duty_in;
   end

   assign overtemp_active = ot_r;
   assign temperature_span = range_r[`SPAN_MSB:`SPAN_LSB];
   assign config_locked = locked;

   span_decode u_span (
      .span_code(range_r[`SPAN_MSB:`SPAN_LSB]),
      .span_q2(span_quarter_deg)
   );
endmodule // peci_limit_regs

// >>> dv/peci_limit_asserts.sv
// port assertions for the peci limit bank
// assumes bind onto peci_limit_regs below
`timescale 1ns/10ps
module peci_limit_asserts #(parameter int NUM_PWM = 3) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [1:0] response,
   input wire logic [8*NUM_PWM-1:0] pwm_duty_in,
   input wire logic [8*NUM_PWM-1:0] pwm_duty_out,
   input wire logic overtemp_active,
   input wire logic [3:0] temperature_span,
   input wire logic [9:0] span_quarter_deg,
   input wire logic config_locked
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_ack_hold: assert property ((read || write) && !waitrequest ##1 (read || write) |-> waitrequest)
      else $error("no idle after ack");
   a_span_dec: assert property (temperature_span == 4'hc |-> span_quarter_deg == 10'd128)
      else $error("span decode");
   a_lock_stick: assert property (config_locked |=> config_locked)
      else $error("lock lost");
   a_span_frozen: assert property (config_locked |=> $stable(temperature_span))
      else $error("span changed");
   a_full_duty: assert property (overtemp_active |=> pwm_duty_out == '1)
      else $error("duty not full");
   a_normal_duty: assert property (!overtemp_active |=> pwm_duty_out == $past(pwm_duty_in))
      else $error("duty not passed");
   a_bad_addr: assert property (read && !waitrequest && address == 8'h3e |-> response == 2'b11)
      else $error("unmapped ok");
   a_version_caps: assert property (read && !waitrequest && address == 8'h3f |-> readdata[3:2] == 2'b11)
      else $error("caps");
endmodule // peci_limit_asserts
bind peci_limit_regs peci_limit_asserts #(.NUM_PWM(NUM_PWM)) u_chk (.*);

// >>> dv/tb.sv
// self-checking bench for the peci limit bank
// assumes the checker binds itself
`timescale 1ns/10ps
module tb;
   import peci_limit_pkg::*;
   logic mclk = 0, rst = 1, read = 0, write = 0, overtemp_active, waitrequest, config_locked;
   logic [7:0] address = 0, hysteresis = 8'h05;
   logic [31:0] writedata = 0, readdata, peci_temp = 0;
   logic [3:0] byteenable = 4'hf, peci_valid = 4'h1, temperature_span;
   logic [23:0] pwm_duty_in = 24'h123456, pwm_duty_out;
   logic [1:0] response;
   logic [9:0] span_quarter_deg;
   reg8_t rdata;
   int failures = 0, comparisons = 0;
   peci_limit_regs u_peci_limit_regs (.*);
   initial forever #20 mclk = ~mclk;
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= {24'h0, d};
      do @(posedge mclk); while (waitrequest !== 1'b0);
      rdata = readdata[7:0];
      read <= 0;
      write <= 0;
   endtask
   task report_and_stop;
      if (failures == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task t_reset;
      acc(0, 8'h3c, 0);
      chk("range", rdata, 8'hc0);
      chk("span rst", span_quarter_deg, 10'd128);
      acc(0, 8'h3d, 0);
      chk("limit", rdata, 8'h00);
      acc(1, 8'h3f, 8'hff);
      acc(0, 8'h3f, 0);
      chk("version", rdata, 8'h1c);
      acc(0, 8'h3e, 0);
      chk("unmapped", response, 2'b11);
   endtask
   task automatic t_span;
      int q[16] = '{8, 10, 13, 16, 20, 26, 32, 40, 53, 64, 80, 106, 128, 160, 213, 320};
      for (int c = 0; c < 16; c++) begin
         acc(1, 8'h3c, 8'(c * 16 + 5));
         acc(0, 8'h3c, 0);
         chk("span", span_quarter_deg, q[c]);
         chk("span code", temperature_span, c);
         chk("range rb", rdata, c * 16 + 5);
      end
   endtask
   task t_b2b;
      @(posedge mclk);
      address <= 8'h3f;
      read <= 1;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      chk("b2b version", readdata, 32'h1c);
      address <= 8'h3d;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      chk("b2b limit", readdata, 32'h80);
      read <= 0;
   endtask
   task t_override;
      acc(1, 8'h3d, 8'h50);
      peci_temp <= 32'h51;
      repeat (4) @(posedge mclk);
      chk("ot on", pwm_duty_out, 24'hffffff);
      peci_temp <= 32'h4c;
      repeat (4) @(posedge mclk);
      chk("ot held", overtemp_active, 1'b1);
      peci_temp <= 32'h4a;
      repeat (4) @(posedge mclk);
      chk("ot off", pwm_duty_out, 24'h123456);
      acc(1, 8'h3d, 8'h80);
      peci_temp <= 32'h51;
      repeat (4) @(posedge mclk);
      chk("ot disabled", overtemp_active, 1'b0);
   endtask
   task t_lock;
      acc(1, 8'h40, 8'h02);
      acc(1, 8'h3c, 8'h11);
      acc(1, 8'h3d, 8'h22);
      acc(1, 8'h40, 8'h00);
      chk("lock", config_locked, 1'b1);
      acc(0, 8'h3c, 0);
      chk("range locked", rdata, 8'hf5);
      acc(0, 8'h3d, 0);
      chk("limit locked", rdata, 8'h80);
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 0;
      t_reset;
      t_span;
      t_override;
      t_lock;
      t_b2b;
      report_and_stop;
   end
   initial begin
      #50us;
      failures++;
      report_and_stop;
   end
endmodule // tb
